// ===== hdl/rsq_consts.svh
// constants of the reset and initialisation sequencer
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH
`define RSQ_REG_CTRL 6'h00
`define RSQ_REG_KICK 6'h01
`define RSQ_REG_STATUS 6'h02
`define RSQ_REG_CONFIG 6'h03
`define RSQ_REG_BOOTID 6'h04
`define RSQ_REG_BUSCMD 6'h05
`define RSQ_REG_SERVICE 6'h06
`define RSQ_REG_IO 6'h07
`define RSQ_REG_IODIR 6'h08
`define RSQ_REG_CHKSUM 6'h09
`define RSQ_REG_RAM 6'h10
`define RSQ_RAM_DEV_ADDR 16'he800
`define RSQ_CTRL_SWRST 0
`define RSQ_BUSCMD_WR 24
`define RSQ_BUSCMD_GO 25
`define RSQ_BOOTID_RST 17'h00000
`define RSQ_SERVICE_RST 2'h2
`define RSQ_RST_PULSE_CYCLES 9'h100
`define RSQ_WDOG_MS 840
`define RSQ_WDOG_REF_KHZ 10000
`define RSQ_WDOG_CYCLES (`RSQ_WDOG_MS * `RSQ_WDOG_REF_KHZ)
`define RSQ_STAB_CYCLES 2048
`define RSQ_SELFTEST_CYCLES 386000
`define RSQ_SVC_CYCLES 1000
`define RSQ_STATE_NOBOOT_CYCLES 250
`define RSQ_STATE_BOOT_CYCLES 2275000
`define RSQ_SYSRAM_BASE 21000
`define RSQ_SYSRAM_PER_BUF 600
`define RSQ_CHK_BASE 3400
`define RSQ_CHK_PER_BYTE 175
`define RSQ_TIMER_CYCLES 6100
`define RSQ_SCHED_CYCLES 7400
`define RSQ_ST_OK 8'h00
`define RSQ_ST_RAM 8'h01
`define RSQ_ST_TIMER 8'h02
`define RSQ_ST_COUNTER 8'h03
`define RSQ_ST_CLOCK 8'h04
`endif

// ===== hdl/rsq_pkg.sv
// types of the reset and initialisation sequencer
package rsq_pkg;
  typedef enum logic [3:0] {
    S_HOLD, S_STAB, S_SELFTEST, S_SERVICE, S_STATE, S_OFFRAM, S_SEED,
    S_SYSRAM, S_COMM, S_CHKSUM, S_TIMER, S_SCHED, S_RUN
  } rsq_state_t;
  typedef struct packed {
    logic ram;
    logic timer;
    logic counter;
    logic clock_fast;
  } rsq_selftest_t;
  typedef struct packed {
    logic [15:0] addr;
    logic addr_oe;
    logic rw;
    logic strobe;
    logic ctl_oe;
    logic [7:0] data;
    logic data_oe;
  } rsq_bus_t;
endpackage

// ===== hdl/rsq_top.sv
// reset pin, watchdogs and start-up step sequencer with axi4-lite regs
// Function
// - hold reset pin low while supply rises
// - drive reset pin low below minimum supply
// - watchdog or software reset: 256-cycle low pulse
// - three watchdogs, any expiry resets device
// - watchdog period is fixed 840 ms count
// - watchdogs always active, never disabled
// - tristate select and reset low: outputs high-z
// - reset: address ffff, rw 0, strobe 1
// - reset: data lines driven low
// - outside reset, data driven only writes, strobe low phase
// - reset: service pin high-z, no pull-up
// - i/o high-z until start-up steps reach run
// - strobe high, address ones right after reset
// - start-up steps run in fixed order
// - self-test sets flag, clears ram
// - self-test code into first ram byte
// - ram failure: still reaches run, service on, logged
// - self-test blinks service; then off high
// - boot when blank or boot id differs
// - checksums generated after boot, else checked
// - self-test, service, timer, scheduler budgets
// - state, sysram, checksum step budgets
`timescale 1ns/1ps
`include "rsq_consts.svh"
module rsq_top import rsq_pkg::*; #(
  parameter int RAM_BYTES = 8,
  parameter int IO_WIDTH = 12,
  parameter int BLINK_BIT = 15,
  parameter int STAB_CYCLES = `RSQ_STAB_CYCLES,
  parameter int WDOG_CYCLES = `RSQ_WDOG_CYCLES,
  parameter int SELFTEST_CYCLES = `RSQ_SELFTEST_CYCLES,
  parameter int BOOT_CYCLES = `RSQ_STATE_BOOT_CYCLES,
  parameter int SYSRAM_BASE = `RSQ_SYSRAM_BASE,
  parameter int TIMER_CYCLES = `RSQ_TIMER_CYCLES,
  parameter int SCHED_CYCLES = `RSQ_SCHED_CYCLES,
  // arbitrary value
  parameter logic [15:0] ROM_BOOT_ID = 16'h5a3c
) (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_NRST,
  // axi4-lite slave
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [7:0] I_AXI_AWADDR,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  output logic [1:0] O_AXI_BRESP,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  input wire logic [7:0] I_AXI_ARADDR,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  // supply, reset pin, test and self-test
  input wire logic I_SUPPLY_OK,
  input wire logic I_RESET_PIN,
  output logic O_RESET_PIN,
  output logic O_RESET_PIN_OE,
  input wire logic I_TEST_TRISTATE_SELECT,
  input wire rsq_selftest_t I_SELFTEST,
  // external memory bus
  output rsq_bus_t O_BUS,
  input wire logic [7:0] I_BUS_DATA,
  // service pin
  output logic O_SERVICE_PIN,
  output logic O_SERVICE_OE,
  output logic O_SERVICE_PULLUP,
  // general i/o and state
  output logic [IO_WIDTH-1:0] O_IO,
  output logic [IO_WIDTH-1:0] O_IO_OE,
  output logic O_RUNNING
);
  if (RAM_BYTES < 2 || RAM_BYTES > 16 || IO_WIDTH > 16 ||
      BLINK_BIT > 30 || WDOG_CYCLES < 2) begin : g_chk
    $error("rsq_top: unsupported parameter values");
  end

  localparam int HALF = RAM_BYTES / 2;
  rsq_state_t state_ff;
  logic [31:0] cnt_ff, step_len;
  logic pin_meta_ff, pin_sync_ff, rst_low, tst;
  logic [8:0] pulse_cnt_ff, nxt_pulse_cnt;
  logic [2:0] wd_exp;
  logic sw_trig, trig, done, st_end;
  logic [7:0] code_nxt, built_in_self_test_code_ff, cfg_sum, app_sum, rd_byte_ff;
  logic built_in_self_test_fail_ff, ram_fail_ff, boot_ff, chk_err_ff, wd_cause_ff;
  logic [7:0] ram_ff [RAM_BYTES];
  logic [7:0] nbuf_ff;
  logic [15:0] nchk_ff, cfg_chk_ff;
  logic [16:0] bootid_ff;
  logic [25:0] buscmd_ff;
  logic [1:0] bus_ph_ff, svc_ff;
  logic [IO_WIDTH-1:0] io_ff, iodir_ff;
  logic aw_got_ff, w_got_ff, do_wr;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;

  function automatic logic reg_ok(input logic [7:0] a);
    reg_ok = a[7:2] <= `RSQ_REG_CHKSUM ||
      (a[7:2] >= `RSQ_REG_RAM && a[7:2] < `RSQ_REG_RAM + 6'(RAM_BYTES));
  endfunction
  function automatic logic [31:0] wmerge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[8*i +: 8] = d[8*i +: 8];
    end
    wmerge = o;
  endfunction
  function automatic logic hit(input logic [5:0] idx);
    hit = do_wr && aw_addr_ff[7:2] == idx;
  endfunction

  // synchroniser; external drivers only pull low, never high
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= I_RESET_PIN;
      pin_sync_ff <= pin_meta_ff;
    end
  end
  // own drive counts at once, pin level after synchronisation
  assign rst_low = !pin_sync_ff || O_RESET_PIN_OE;
  assign tst = I_TEST_TRISTATE_SELECT && !pin_sync_ff;

  // three watchdogs; no enable exists, only restart by kick, own expiry or reset
  for (genvar g = 0; g < 3; g++) begin : g_wd
    logic [31:0] wd_ff;
    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
      if (!I_NRST) begin
        wd_ff <= 32'h0;
      end else if (rst_low || wd_exp[g] ||
          (hit(`RSQ_REG_KICK) && w_data_ff[g])) begin
        wd_ff <= 32'h0;
      end else begin
        wd_ff <= wd_ff + 32'h1;
      end
    end
    assign wd_exp[g] = wd_ff == 32'(WDOG_CYCLES - 1);
  end

  assign sw_trig = hit(`RSQ_REG_CTRL) && w_data_ff[`RSQ_CTRL_SWRST];
  // a running pulse is never restretched, so it is exactly 256 long
  assign trig = (sw_trig || |wd_exp) && pulse_cnt_ff == 9'h0;
  always_comb begin
    nxt_pulse_cnt = pulse_cnt_ff;
    if (trig) nxt_pulse_cnt = `RSQ_RST_PULSE_CYCLES;
    else if (pulse_cnt_ff != 9'h0) nxt_pulse_cnt = pulse_cnt_ff - 9'h1;
  end
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      pulse_cnt_ff <= 9'h0;
      O_RESET_PIN_OE <= 1'b1;
      O_RESET_PIN <= 1'b0;
      wd_cause_ff <= 1'b0;
    end else begin
      pulse_cnt_ff <= nxt_pulse_cnt;
      O_RESET_PIN_OE <= !I_SUPPLY_OK || nxt_pulse_cnt != 9'h0;
      O_RESET_PIN <= 1'b0;
      if (trig) wd_cause_ff <= |wd_exp;
    end
  end

  always_comb begin
    case (state_ff)
      S_HOLD: step_len = 32'h1;
      S_STAB: step_len = 32'(STAB_CYCLES);
      S_SELFTEST: step_len = 32'(SELFTEST_CYCLES);
      S_SERVICE: step_len = 32'(`RSQ_SVC_CYCLES);
      S_STATE: step_len = boot_ff ? 32'(BOOT_CYCLES) :
        32'(`RSQ_STATE_NOBOOT_CYCLES);
      S_SYSRAM: step_len = 32'(SYSRAM_BASE) +
        32'(`RSQ_SYSRAM_PER_BUF) * 32'(nbuf_ff);
      S_CHKSUM: step_len = 32'(`RSQ_CHK_BASE) +
        32'(`RSQ_CHK_PER_BYTE) * 32'(nchk_ff);
      S_TIMER: step_len = 32'(TIMER_CYCLES);
      S_SCHED: step_len = 32'(SCHED_CYCLES);
      default: step_len = 32'h1;
    endcase
  end
  assign done = state_ff != S_RUN && cnt_ff >= step_len - 32'h1;
  assign st_end = done && state_ff == S_SELFTEST;

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_ff <= S_HOLD;
      cnt_ff <= 32'h0;
    end else if (rst_low) begin
      state_ff <= S_HOLD;
      cnt_ff <= 32'h0;
    end else if (done) begin
      state_ff <= rsq_state_t'(state_ff + 4'h1);
      cnt_ff <= 32'h0;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  always_comb begin
    if (I_SELFTEST.ram) code_nxt = `RSQ_ST_RAM;
    else if (I_SELFTEST.timer) code_nxt = `RSQ_ST_TIMER;
    else if (I_SELFTEST.counter) code_nxt = `RSQ_ST_COUNTER;
    else if (I_SELFTEST.clock_fast) code_nxt = `RSQ_ST_CLOCK;
    else code_nxt = `RSQ_ST_OK;
  end
  always_comb begin
    cfg_sum = 8'h0;
    app_sum = 8'h0;
    for (int i = 0; i < RAM_BYTES; i++) begin
      if (i < HALF) cfg_sum = cfg_sum + ram_ff[i];
      else app_sum = app_sum + ram_ff[i];
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      built_in_self_test_code_ff <= `RSQ_ST_OK;
      built_in_self_test_fail_ff <= 1'b0;
      ram_fail_ff <= 1'b0;
      boot_ff <= 1'b0;
      chk_err_ff <= 1'b0;
    end else begin
      if (st_end) begin
        built_in_self_test_code_ff <= code_nxt;
        built_in_self_test_fail_ff <= code_nxt != `RSQ_ST_OK;
        ram_fail_ff <= I_SELFTEST.ram;
      end
      if (state_ff == S_STATE && cnt_ff == 32'h0) begin
        boot_ff <= !bootid_ff[16] || bootid_ff[15:0] != ROM_BOOT_ID;
      end
      if (done && state_ff == S_CHKSUM) begin
        chk_err_ff <= !boot_ff && (cfg_sum + cfg_chk_ff[7:0] != 8'h0 ||
          app_sum + cfg_chk_ff[15:8] != 8'h0);
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int i = 0; i < RAM_BYTES; i++) ram_ff[i] <= 8'h0;
    end else if (st_end) begin
      for (int i = 1; i < RAM_BYTES; i++) ram_ff[i] <= 8'h0;
      ram_ff[0] <= code_nxt;
    end else begin
      for (int i = 0; i < RAM_BYTES; i++) begin
        if (hit(`RSQ_REG_RAM + 6'(i)) && w_strb_ff[0]) begin
          ram_ff[i] <= w_data_ff[7:0];
        end
      end
    end
  end

  // nonvolatile stand-ins: only power-on reset clears them
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      bootid_ff <= `RSQ_BOOTID_RST;
      cfg_chk_ff <= 16'h0;
      nbuf_ff <= 8'h0;
      nchk_ff <= 16'h0;
    end else begin
      if (boot_ff && done && state_ff == S_STATE) begin
        bootid_ff <= {1'b1, ROM_BOOT_ID};
      end else if (hit(`RSQ_REG_BOOTID)) begin
        bootid_ff <= 17'(wmerge(32'(bootid_ff), w_data_ff, w_strb_ff));
      end
      if (boot_ff && done && state_ff == S_CHKSUM) begin
        cfg_chk_ff <= {8'h0 - app_sum, 8'h0 - cfg_sum};
      end else if (hit(`RSQ_REG_CHKSUM)) begin
        cfg_chk_ff <= 16'(wmerge(32'(cfg_chk_ff), w_data_ff, w_strb_ff));
      end
      if (hit(`RSQ_REG_CONFIG)) begin
        {nchk_ff, nbuf_ff} <= 24'(wmerge({8'h0, nchk_ff, nbuf_ff},
          w_data_ff, w_strb_ff));
      end
    end
  end

  // bus engine: go starts strobe-high phase, then strobe-low phase
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      buscmd_ff <= 26'h0;
      bus_ph_ff <= 2'h0;
      rd_byte_ff <= 8'h0;
      svc_ff <= `RSQ_SERVICE_RST;
      io_ff <= '0;
      iodir_ff <= '0;
    end else begin
      if (hit(`RSQ_REG_BUSCMD) && bus_ph_ff == 2'h0) begin
        buscmd_ff <= 26'(wmerge(32'(buscmd_ff), w_data_ff, w_strb_ff));
      end else if (bus_ph_ff == 2'h2) begin
        buscmd_ff[`RSQ_BUSCMD_GO] <= 1'b0;
      end
      if (rst_low) bus_ph_ff <= 2'h0;
      else if (bus_ph_ff == 2'h2) bus_ph_ff <= 2'h0;
      else if (bus_ph_ff == 2'h1) bus_ph_ff <= 2'h2;
      else if (buscmd_ff[`RSQ_BUSCMD_GO] && state_ff == S_RUN) begin
        bus_ph_ff <= 2'h1;
      end
      if (bus_ph_ff == 2'h2 && !buscmd_ff[`RSQ_BUSCMD_WR]) begin
        rd_byte_ff <= I_BUS_DATA;
      end
      if (hit(`RSQ_REG_SERVICE)) svc_ff <= w_data_ff[1:0];
      if (hit(`RSQ_REG_IO)) io_ff <= w_data_ff[IO_WIDTH-1:0];
      if (hit(`RSQ_REG_IODIR)) iodir_ff <= w_data_ff[IO_WIDTH-1:0];
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_BUS <= '{16'hffff, 1'b1, 1'b0, 1'b1, 1'b1, 8'h0, 1'b1};
    end else if (rst_low) begin
      O_BUS <= '{16'hffff, !tst, 1'b0, 1'b1, !tst, 8'h0, !tst};
    end else begin
      O_BUS.addr <= bus_ph_ff != 2'h0 ? buscmd_ff[15:0] : 16'hffff;
      O_BUS.addr_oe <= 1'b1;
      O_BUS.rw <= bus_ph_ff == 2'h0 || !buscmd_ff[`RSQ_BUSCMD_WR];
      O_BUS.ctl_oe <= 1'b1;
      // next phase is low when the engine moves from high
      O_BUS.strobe <= bus_ph_ff != 2'h1;
      O_BUS.data <= buscmd_ff[23:16];
      O_BUS.data_oe <= bus_ph_ff == 2'h1 &&
        buscmd_ff[`RSQ_BUSCMD_WR];
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_SERVICE_PIN <= 1'b0;
      O_SERVICE_OE <= 1'b0;
      O_SERVICE_PULLUP <= 1'b0;
      O_IO <= '0;
      O_IO_OE <= '0;
      O_RUNNING <= 1'b0;
    end else begin
      O_SERVICE_PIN <= 1'b0;
      O_IO <= io_ff;
      O_IO_OE <= (state_ff == S_RUN && !tst) ? iodir_ff : '0;
      O_RUNNING <= state_ff == S_RUN;
      if (rst_low) begin
        O_SERVICE_OE <= 1'b0;
        O_SERVICE_PULLUP <= 1'b0;
      end else if (state_ff == S_SELFTEST) begin
        O_SERVICE_OE <= cnt_ff[BLINK_BIT];
        O_SERVICE_PULLUP <= 1'b1;
      end else if (state_ff != S_RUN) begin
        O_SERVICE_OE <= 1'b0;
        O_SERVICE_PULLUP <= 1'b1;
      end else begin
        O_SERVICE_OE <= ram_fail_ff || svc_ff[0];
        O_SERVICE_PULLUP <= svc_ff[1];
      end
    end
  end

  // axi4-lite: one write and one read in flight, answers one cycle late
  assign do_wr = aw_got_ff && w_got_ff && !O_AXI_BVALID;
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 8'h0;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      O_AXI_AWREADY <= 1'b1;
      O_AXI_WREADY <= 1'b1;
      O_AXI_BVALID <= 1'b0;
      O_AXI_BRESP <= 2'h0;
    end else begin
      if (I_AXI_AWVALID && O_AXI_AWREADY) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= I_AXI_AWADDR;
        O_AXI_AWREADY <= 1'b0;
      end
      if (I_AXI_WVALID && O_AXI_WREADY) begin
        w_got_ff <= 1'b1;
        w_data_ff <= I_AXI_WDATA;
        w_strb_ff <= I_AXI_WSTRB;
        O_AXI_WREADY <= 1'b0;
      end
      if (do_wr) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        O_AXI_BVALID <= 1'b1;
        O_AXI_BRESP <= reg_ok(aw_addr_ff) ? 2'h0 : 2'h2;
      end
      if (O_AXI_BVALID && I_AXI_BREADY) begin
        O_AXI_BVALID <= 1'b0;
        O_AXI_AWREADY <= 1'b1;
        O_AXI_WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_AXI_ARREADY <= 1'b1;
      O_AXI_RVALID <= 1'b0;
      O_AXI_RDATA <= 32'h0;
      O_AXI_RRESP <= 2'h0;
    end else if (I_AXI_ARVALID && O_AXI_ARREADY) begin
      O_AXI_ARREADY <= 1'b0;
      O_AXI_RVALID <= 1'b1;
      O_AXI_RRESP <= reg_ok(I_AXI_ARADDR) ? 2'h0 : 2'h2;
      case (I_AXI_ARADDR[7:2])
        `RSQ_REG_STATUS: O_AXI_RDATA <= {built_in_self_test_code_ff, 12'h0,
          wd_cause_ff, !pin_sync_ff, ram_fail_ff, chk_err_ff, boot_ff,
          built_in_self_test_fail_ff, ram_fail_ff, state_ff == S_RUN, state_ff};
        `RSQ_REG_CONFIG: O_AXI_RDATA <= {8'h0, nchk_ff, nbuf_ff};
        `RSQ_REG_BOOTID: O_AXI_RDATA <= 32'(bootid_ff);
        `RSQ_REG_BUSCMD: O_AXI_RDATA <= {5'h0, bus_ph_ff != 2'h0,
          buscmd_ff[25:24], rd_byte_ff, buscmd_ff[15:0]};
        `RSQ_REG_SERVICE: O_AXI_RDATA <= 32'(svc_ff);
        `RSQ_REG_IO: O_AXI_RDATA <= 32'(io_ff);
        `RSQ_REG_IODIR: O_AXI_RDATA <= 32'(iodir_ff);
        `RSQ_REG_CHKSUM: O_AXI_RDATA <= 32'(cfg_chk_ff);
        default: O_AXI_RDATA <= 32'h0;
      endcase
      for (int i = 0; i < RAM_BYTES; i++) begin
        if (I_AXI_ARADDR[7:2] == `RSQ_REG_RAM + 6'(i)) begin
          O_AXI_RDATA <= 32'(ram_ff[i]);
        end
      end
    end else if (O_AXI_RVALID && I_AXI_RREADY) begin
      O_AXI_RVALID <= 1'b0;
      O_AXI_ARREADY <= 1'b1;
    end
  end

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_NRST);
  a_lvd_drive: assert property (!I_SUPPLY_OK |=>
    O_RESET_PIN_OE && !O_RESET_PIN) else $error("supply low, pin free");
  a_pulse_len: assert property (trig |=> O_RESET_PIN_OE
    ##255 (O_RESET_PIN_OE && pulse_cnt_ff == 9'h1) ##1
    pulse_cnt_ff == 9'h0) else $error("reset pulse not 256 cycles");
  a_wdog_reset: assert property (|wd_exp |=>
    O_RESET_PIN_OE) else $error("watchdog expiry without reset");
  a_tristate_out: assert property (tst |=> !O_BUS.data_oe &&
    !O_BUS.addr_oe && !O_BUS.ctl_oe && O_IO_OE == '0 && !O_SERVICE_OE)
    else $error("outputs driven in tristate test");
  a_reset_bus: assert property ((rst_low && !tst) |=>
    O_BUS.addr == 16'hffff && O_BUS.strobe && !O_BUS.rw &&
    O_BUS.data_oe && O_BUS.data == 8'h0) else $error("bad reset bus");
  a_data_window: assert property ((O_BUS.data_oe && !$past(rst_low)) |->
    !O_BUS.strobe && !O_BUS.rw) else $error("data outside write");
  a_service_off: assert property (rst_low |=>
    !O_SERVICE_OE && !O_SERVICE_PULLUP) else $error("service in reset");
  a_io_hiz: assert property ((state_ff != S_RUN) |=>
    O_IO_OE == '0) else $error("i/o driven before run");
  a_step_order: assert property ((state_ff != $past(state_ff)) |->
    state_ff == S_HOLD || state_ff == rsq_state_t'($past(state_ff) + 4'h1))
    else $error("step out of order");
  a_built_in_self_test_code: assert property (st_end |=> ram_ff[0] ==
    $past(code_nxt) && built_in_self_test_fail_ff == ($past(code_nxt) != 8'h0))
    else $error("self-test code not stored");
  a_offline_led: assert property ((state_ff == S_RUN && ram_fail_ff &&
    !rst_low) |=> O_SERVICE_OE)
    else $error("service not on after ram failure");
  a_state_len: assert property ((state_ff == S_STATE && !boot_ff &&
    done && !rst_low) |-> cnt_ff == 32'd249) else $error("state step len");
  c_reach_run: cover property ($rose(state_ff == S_RUN));
  c_wdog_fire: cover property (|wd_exp);
  c_tristate: cover property (tst);
  c_bus_write: cover property (O_BUS.data_oe && state_ff == S_RUN);
endmodule // rsq_top

// ===== verif/rsq_ext_model.sv
// far side: open-drain reset source and external memory device
`timescale 1ns/1ps
module rsq_ext_model import rsq_pkg::*; (
  // clock
  input wire logic i_clock,
  // reset pin parties
  input wire logic i_dev_oe,
  input wire logic i_ext_pull,
  output logic o_reset_pin,
  // memory bus
  input wire rsq_bus_t i_bus,
  output logic [7:0] o_bus_data
);
  logic [7:0] last_ff;
  // wired low with pull-up, nobody drives high
  assign o_reset_pin = !(i_dev_oe || i_ext_pull);
  // unselected bus shows a changing pattern, not a held value
  assign o_bus_data = (i_bus.ctl_oe && i_bus.rw && !i_bus.strobe) ?
    (8'h3c ^ i_bus.addr[7:0]) : ~last_ff;
  always_ff @(posedge i_clock) begin
    last_ff <= o_bus_data;
  end
endmodule // rsq_ext_model

// ===== verif/tb.sv
// self-checking bench of the reset and start-up sequencer
`timescale 1ns/1ps
`include "rsq_consts.svh"
module tb import rsq_pkg::*;;
  localparam int WDOG = 20000;
  logic clk, nrst, awv, wv, bry, arv, rry, sup, tts, pull;
  logic awr, wrdy, bv, arr, rv, oe, pin, opin, run, svc, svc_oe, svc_pu;
  logic oe_q;
  logic [7:0] awa, ara, bdata;
  logic [31:0] wd, rdata, v;
  logic [1:0] br, rr;
  logic [3:0] strb;
  logic [11:0] io, io_oe;
  rsq_selftest_t st;
  rsq_bus_t bus;
  int n_errors, n_tests, cyc, t_rise, t_fall, k;

  // only the longest steps are shortened; the rest keep real counts
  rsq_top #(.WDOG_CYCLES(WDOG), .SELFTEST_CYCLES(40), .BOOT_CYCLES(30),
    .SYSRAM_BASE(20), .SCHED_CYCLES(10)) uut (
    .I_CLOCK(clk), .I_NRST(nrst),
    .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_AWADDR(awa),
    .I_AXI_WVALID(wv), .O_AXI_WREADY(wrdy), .I_AXI_WDATA(wd),
    .I_AXI_WSTRB(strb), .O_AXI_BVALID(bv), .I_AXI_BREADY(bry),
    .O_AXI_BRESP(br), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
    .I_AXI_ARADDR(ara), .O_AXI_RVALID(rv), .I_AXI_RREADY(rry),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rr), .I_SUPPLY_OK(sup),
    .I_RESET_PIN(pin), .O_RESET_PIN(opin), .O_RESET_PIN_OE(oe),
    .I_TEST_TRISTATE_SELECT(tts), .I_SELFTEST(st), .O_BUS(bus),
    .I_BUS_DATA(bdata), .O_SERVICE_PIN(svc), .O_SERVICE_OE(svc_oe),
    .O_SERVICE_PULLUP(svc_pu), .O_IO(io), .O_IO_OE(io_oe),
    .O_RUNNING(run));

  rsq_ext_model partner (.i_clock(clk), .i_dev_oe(oe), .i_ext_pull(pull),
    .o_reset_pin(pin), .i_bus(bus), .o_bus_data(bdata));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task summarize;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task wr(input logic [5:0] i, input logic [31:0] d);
    @(posedge clk);
    awv <= 1; wv <= 1; awa <= {i, 2'b00}; wd <= d; bry <= 1;
    forever begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
      if (bv === 1'b1) break;
    end
    bry <= 0;
  endtask

  task rd(input logic [5:0] i, output logic [31:0] d);
    @(posedge clk);
    arv <= 1; ara <= {i, 2'b00}; rry <= 1;
    forever begin
      @(posedge clk);
      if (arr) arv <= 0;
      if (rv === 1'b1) break;
    end
    d = rdata;
    rry <= 0;
  endtask

  task wait_run;
    k = 0;
    while (run !== 1'b1 && k < 15000) begin
      @(posedge clk);
      k++;
    end
    chk("running", 1, run);
  endtask

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // edge times of the pin drive; hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    oe_q <= oe;
    if (oe === 1'b1 && oe_q !== 1'b1) t_rise <= cyc;
    if (oe !== 1'b1 && oe_q === 1'b1) t_fall <= cyc;
    if (cyc > 60000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    {nrst, awv, wv, bry, arv, rry, tts, pull, oe_q} = '0;
    {awa, ara, wd} = '0;
    sup = 1; st = '0; cyc = 0; t_rise = 0; t_fall = 0;
    strb = 4'hf;
    repeat (8) @(posedge clk);
    chk("bus in reset", {16'hffff, 4'hb, 8'h00, 1'b1}, bus);
    chk("pins in reset", 0, {svc_oe, svc_pu, io_oe});
    chk("pin drive in reset", 1, oe);
    nrst <= 1;
    wr(`RSQ_REG_CONFIG, 0);
    sup <= 0;
    repeat (3) @(posedge clk);
    chk("low supply drive", 1, oe);
    sup <= 1; pull <= 1; tts <= 1;
    repeat (4) @(posedge clk);
    chk("tristate", 0, {bus.addr_oe, bus.ctl_oe, bus.data_oe, svc_oe,
      io_oe});
    tts <= 0; pull <= 0;
    wait_run();
    rd(`RSQ_REG_STATUS, v);
    chk("selftest code", `RSQ_ST_OK, v[31:24]);
    rd(`RSQ_REG_RAM, v);
    chk("ram byte 0", 0, v[7:0]);
    chk("service off", 0, svc_oe);
    // only lane 1 lands; the stored app checksum no longer matches
    strb <= 4'h2;
    wr(`RSQ_REG_CHKSUM, 32'h0000abcd);
    strb <= 4'hf;
    rd(`RSQ_REG_CHKSUM, v);
    chk("checksum lanes", 32'h0000ab00, v);
    wr(`RSQ_REG_BUSCMD, 32'h03a51234);
    for (k = 0; k < 20 && bus.strobe !== 1'b0; k++) @(posedge clk);
    chk("bus write", {16'h1234, 1'b0, 8'ha5, 1'b1},
      {bus.addr, bus.rw, bus.data, bus.data_oe});
    wr(`RSQ_REG_BUSCMD, 32'h02000042);
    repeat (10) @(posedge clk);
    rd(`RSQ_REG_BUSCMD, v);
    chk("bus read", {1'b0, 8'h7e}, {v[26], v[23:16]});
    wr(`RSQ_REG_CTRL, 1);
    repeat (300) @(posedge clk);
    chk("reset pulse", 256, t_fall - t_rise);
    wait_run();
    // only two of three watchdogs are kept alive
    while (t_rise < t_fall && cyc < 55000) begin
      wr(`RSQ_REG_KICK, 3);
      repeat (300) @(posedge clk);
    end
    chk("watchdog period", 1,
      (t_rise - t_fall >= WDOG) && (t_rise - t_fall <= WDOG + 8));
    st <= 4'b1000;
    // let the running flag drop before waiting for it again
    repeat (2) @(posedge clk);
    wait_run();
    rd(`RSQ_REG_STATUS, v);
    chk("ram fail code", `RSQ_ST_RAM, v[31:24]);
    chk("service on", 1, svc_oe);
    chk("checksum error", 1, v[8]);
    chk("watchdog cause", 1, v[11]);
    summarize();
  end
endmodule // tb
